// file: hw/aisk_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the task-file block
// Assumes: 40 MHz pclk; APB byte address is four times the register index
// Notes:   definitions only
`ifndef AISK_DEFINES_SVH
`define AISK_DEFINES_SVH

// ********************************************************************
// register indices (byte address = index * 4)
// ********************************************************************
`define AISK_IDX_DATA       5'h00
`define AISK_IDX_FEATURE    5'h01
`define AISK_IDX_XFER_CNT   5'h02
`define AISK_IDX_START_SEC  5'h03
`define AISK_IDX_TRACK_LO   5'h04
`define AISK_IDX_TRACK_HI   5'h05
`define AISK_IDX_UNIT_HEAD  5'h06
`define AISK_IDX_COMMAND    5'h07
`define AISK_IDX_STATUS     5'h08
`define AISK_IDX_INT_STAT   5'h09
`define AISK_IDX_INT_MASK   5'h0a
`define AISK_IDX_SEC_CTRL   5'h0b
`define AISK_IDX_IDENT_CTRL 5'h0c
`define AISK_IDX_IDENT      5'h0d
`define AISK_IDX_GEOMETRY   5'h0e
`define AISK_IDX_CHAL_LO    5'h0f
`define AISK_IDX_CHAL_HI    5'h10
`define AISK_IDX_APD        5'h11
`define AISK_IDX_LAST       5'h11

// ********************************************************************
// command codes
// ********************************************************************
`define AISK_CMD_IDLE_A     8'h97
`define AISK_CMD_IDLE_B     8'he3
`define AISK_CMD_IDLE_IMM_A 8'h95
`define AISK_CMD_IDLE_IMM_B 8'he1
`define AISK_CMD_INIT_GEOM  8'h91
`define AISK_CMD_KEY_MGMT   8'hb9
`define AISK_CMD_SEC_UNLOCK 8'hf2
`define AISK_CMD_SEC_ERASE  8'hf4

// ********************************************************************
// field positions
// ********************************************************************
`define AISK_INT_DONE       0
`define AISK_INT_DRQ        1
`define AISK_INT_ABORT      2
`define AISK_INT_PDOWN      3
`define AISK_INT_W          4
`define AISK_SEC_CAP        0
`define AISK_SEC_EN         1
`define AISK_SEC_LOCK       2
`define AISK_SEC_FREEZE     3
`define AISK_SEC_EXPIRE     4
`define AISK_SEC_ENH        5
`define AISK_SEC_MAX        8
`define AISK_ID_PIO3        0
`define AISK_ID_PIO4        1
`define AISK_ID_OTHER       2
`define AISK_W53_EXT_VALID  1
`define AISK_FEAT_KEY_HI    7

// ********************************************************************
// reset values
// ********************************************************************
`define AISK_RST_HEADS_M1   4'hf
`define AISK_RST_SPT        8'h3f
`define AISK_RST_KMS_SCHEME 16'h5a01

// ********************************************************************
// timing
// ********************************************************************
`define AISK_CLK_HZ         40000000
`define AISK_CLK_NS         25
`define AISK_APD_UNIT_MS    5
`define AISK_APD_TICK_CYC   ((`AISK_CLK_HZ / 1000) * `AISK_APD_UNIT_MS)
`define AISK_BUSY_NS        100
`define AISK_BUSY_CYC       ((`AISK_BUSY_NS + `AISK_CLK_NS - 1) / `AISK_CLK_NS)
`define AISK_PIO3_CYC_NS    16'h00b4
`define AISK_PIO4_CYC_NS    16'h0078
`define AISK_KMS_WORDS      9'h100

`endif

// file: hw/aisk_pkg.sv
// Purpose: shared types of the task-file command block
// Assumes: nothing beyond the defines header
// Notes:   types only
package aisk_pkg;

	typedef enum logic [1:0] {
		AISK_ST_READY,
		AISK_ST_BUSY,
		AISK_ST_XFER
	} aisk_cmd_state_t;

	typedef enum logic [1:0] {
		AISK_PWR_ACTIVE,
		AISK_PWR_IDLE,
		AISK_PWR_DOWN
	} aisk_power_t;

endpackage : aisk_pkg

// file: hw/aisk_cmd.sv
// Purpose: task-file command interpreter: idle, idle immediate, geometry, key structure read
// Assumes: APB slave, 32-bit data, one aligned word per register index
// Notes:   identify words 53/68 and the security word are built from software config
//
// Overview of operation
// - word 68 reports flow-controlled minimum PIO cycle; word 53 bit 1 set then.
// - PIO mode 3 or faster support means word 68 holds fastest mode time.
// - word 53 bit 1 set only for other fields gives word 68 zero.
// - security bit 8 is one for maximum level while security is enabled, zero for high level or when disabled.
// - security bit 5 is one when enhanced erase unit is supported.
// - bit 4 marks expired count; unlock and erase abort until reset.
// - bit 3 shows frozen security, bit 2 shows locked security.
// - bit 1 shows security enabled versus disabled.
// - bit 0 shows the security feature set is implemented.
// - idle command sets busy, enters idle, clears busy, interrupts.
// - idle with nonzero count enables power-down after count times 5 ms.
// - idle with zero count disables automatic power-down.
// - idle immediate sets busy, enters idle, clears busy, interrupts; ignores parameters.
// - geometry command takes sectors per track and heads minus one.
// - geometry command reads only count and unit/head registers.
// - key command with feature 0-127 returns a 512-byte structure by PIO in.
// - 39-bit host challenge gathered from five parameter registers; any value accepted.
`timescale 1ns/1ps

`include "aisk_defines.svh"

module aisk_cmd #(
	parameter int APD_TICK_CYCLES = `AISK_APD_TICK_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// device status
	output logic             irq,
	output logic             device_occupied_flag,
	output logic             power_down
);

	// ********************************************************************
	// apb decode
	// ********************************************************************
	logic [4:0] idx;
	logic       setup;
	logic       done;
	logic       wr;
	logic       rd;
	logic       mapped;

	assign idx    = paddr[6:2];
	assign mapped = (paddr[31:7] == 25'h0) && (paddr[1:0] == 2'h0) && (idx <= `AISK_IDX_LAST);
	assign setup  = psel && !penable && !pready;
	assign done   = psel && penable && pready;
	assign wr     = done && pwrite && mapped;
	assign rd     = done && !pwrite && mapped;

	function automatic logic wr_at(input logic [4:0] i, input logic w, input logic [4:0] a);
		return w && (i == a);
	endfunction : wr_at

	// ********************************************************************
	// state
	// ********************************************************************
	aisk_pkg::aisk_cmd_state_t state;
	aisk_pkg::aisk_power_t     power;
	logic [7:0]                feature_param;
	logic [7:0]                transfer_count_param;
	logic [7:0]                start_sector_param;
	logic [7:0]                track_low_param;
	logic [7:0]                track_high_param;
	logic [7:0]                unit_head_select;
	logic [7:0]                cmd_latched;
	logic [2:0]                busy_cnt;
	logic [8:0]                kms_idx;
	logic                      error_flag;
	logic [`AISK_INT_W-1:0]    int_status;
	logic [`AISK_INT_W-1:0]    int_mask;
	logic [`AISK_INT_W-1:0]    int_events;
	logic [15:0]               sec_ctrl;
	logic                      sec_expired;
	logic [2:0]                ident_ctrl;
	logic [3:0]                heads_m1;
	logic [7:0]                sectors_per_track;
	logic [38:0]               host_challenge_value;
	logic                      apd_enable;
	logic [7:0]                apd_count;
	logic [7:0]                apd_left;
	logic [17:0]               tick_cnt;
	logic                      apd_tick;
	logic                      apd_expire;
	logic                      cmd_wr;
	logic                      exec;
	logic                      kms_last;
	logic [15:0]               word53;
	logic [15:0]               word68;
	logic [15:0]               sec_word;
	logic [31:0]               next_prdata;

	assign cmd_wr   = wr_at(idx, wr, `AISK_IDX_COMMAND) && (state == aisk_pkg::AISK_ST_READY);
	assign exec     = (state == aisk_pkg::AISK_ST_BUSY) && (busy_cnt == 3'h0);
	assign kms_last = rd && (idx == `AISK_IDX_DATA) && (state == aisk_pkg::AISK_ST_XFER)
		&& (kms_idx == `AISK_KMS_WORDS - 9'h001);

	// ********************************************************************
	// identify words and security word
	// ********************************************************************
	function automatic logic [15:0] min_flow_cycle(input logic [2:0] c);
		if (c[`AISK_ID_PIO4])
			return `AISK_PIO4_CYC_NS;
		else if (c[`AISK_ID_PIO3])
			return `AISK_PIO3_CYC_NS;
		return 16'h0000;
	endfunction : min_flow_cycle

	assign word68 = min_flow_cycle(ident_ctrl);
	assign word53 = {14'h0, |ident_ctrl, 1'b1};

	assign sec_word = {7'h00,
		sec_ctrl[`AISK_SEC_EN] && sec_ctrl[`AISK_SEC_MAX],
		2'h0,
		sec_ctrl[`AISK_SEC_ENH],
		sec_expired,
		sec_ctrl[`AISK_SEC_FREEZE],
		sec_ctrl[`AISK_SEC_LOCK],
		sec_ctrl[`AISK_SEC_EN],
		sec_ctrl[`AISK_SEC_CAP]};

	// key structure content: scheme word, echoed challenge, zero fill
	function automatic logic [15:0] kms_word(input logic [8:0] i, input logic [38:0] c);
		unique case (i)
			9'h000:  return `AISK_RST_KMS_SCHEME;
			9'h001:  return c[15:0];
			9'h002:  return c[31:16];
			9'h003:  return {9'h000, c[38:32]};
			default: return 16'h0000;
		endcase
	endfunction : kms_word

	// ********************************************************************
	// apb answer, zero wait states, data registered in setup
	// ********************************************************************
	always_comb begin
		next_prdata = 32'h0;
		unique case (idx)
			`AISK_IDX_DATA:       next_prdata = (state == aisk_pkg::AISK_ST_XFER) ?
				{16'h0, kms_word(kms_idx, host_challenge_value)} : 32'h0;
			`AISK_IDX_FEATURE:    next_prdata = {24'h0, feature_param};
			`AISK_IDX_XFER_CNT:   next_prdata = {24'h0, transfer_count_param};
			`AISK_IDX_START_SEC:  next_prdata = {24'h0, start_sector_param};
			`AISK_IDX_TRACK_LO:   next_prdata = {24'h0, track_low_param};
			`AISK_IDX_TRACK_HI:   next_prdata = {24'h0, track_high_param};
			`AISK_IDX_UNIT_HEAD:  next_prdata = {24'h0, unit_head_select};
			`AISK_IDX_STATUS:     next_prdata = {27'h0, power, error_flag,
				state == aisk_pkg::AISK_ST_XFER, device_occupied_flag};
			`AISK_IDX_INT_STAT:   next_prdata = {28'h0, int_status};
			`AISK_IDX_INT_MASK:   next_prdata = {28'h0, int_mask};
			`AISK_IDX_SEC_CTRL:   next_prdata = {16'h0, sec_word};
			`AISK_IDX_IDENT_CTRL: next_prdata = {29'h0, ident_ctrl};
			`AISK_IDX_IDENT:      next_prdata = {word68, word53};
			`AISK_IDX_GEOMETRY:   next_prdata = {20'h0, heads_m1, sectors_per_track};
			`AISK_IDX_CHAL_LO:    next_prdata = host_challenge_value[31:0];
			`AISK_IDX_CHAL_HI:    next_prdata = {25'h0, host_challenge_value[38:32]};
			`AISK_IDX_APD:        next_prdata = {15'h0, apd_enable, apd_left, apd_count};
			default:              next_prdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= mapped ? next_prdata : 32'h0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ********************************************************************
	// task-file parameter registers
	// ********************************************************************
	// host writes are dropped while busy, as a real task file would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_param        <= 8'h00;
			transfer_count_param <= 8'h00;
			start_sector_param   <= 8'h00;
			track_low_param      <= 8'h00;
			track_high_param     <= 8'h00;
			unit_head_select     <= 8'h00;
		end else if (wr && !device_occupied_flag) begin
			unique case (idx)
				`AISK_IDX_FEATURE:   feature_param        <= pwdata[7:0];
				`AISK_IDX_XFER_CNT:  transfer_count_param <= pwdata[7:0];
				`AISK_IDX_START_SEC: start_sector_param   <= pwdata[7:0];
				`AISK_IDX_TRACK_LO:  track_low_param      <= pwdata[7:0];
				`AISK_IDX_TRACK_HI:  track_high_param     <= pwdata[7:0];
				`AISK_IDX_UNIT_HEAD: unit_head_select     <= pwdata[7:0];
				default:             ;
			endcase
		end
	end

	// ********************************************************************
	// command sequencer
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= aisk_pkg::AISK_ST_READY;
			device_occupied_flag <= 1'b0;
			cmd_latched          <= 8'h00;
			busy_cnt             <= 3'h0;
			kms_idx              <= 9'h000;
			error_flag           <= 1'b0;
		end else begin
			unique case (state)
				aisk_pkg::AISK_ST_READY: begin
					if (cmd_wr) begin
						state                <= aisk_pkg::AISK_ST_BUSY;
						device_occupied_flag <= 1'b1;
						cmd_latched          <= pwdata[7:0];
						busy_cnt             <= 3'(`AISK_BUSY_CYC - 1);
						error_flag           <= 1'b0;
					end
				end
				aisk_pkg::AISK_ST_BUSY: begin
					if (busy_cnt != 3'h0) begin
						busy_cnt <= busy_cnt - 3'h1;
					end else begin
						device_occupied_flag <= 1'b0;
						if (cmd_latched == `AISK_CMD_KEY_MGMT
							&& !feature_param[`AISK_FEAT_KEY_HI]) begin
							state   <= aisk_pkg::AISK_ST_XFER;
							kms_idx <= 9'h000;
						end else begin
							state      <= aisk_pkg::AISK_ST_READY;
							error_flag <= int_events[`AISK_INT_ABORT];
						end
					end
				end
				aisk_pkg::AISK_ST_XFER: begin
					if (rd && idx == `AISK_IDX_DATA) begin
						kms_idx <= kms_idx + 9'h001;
						if (kms_last)
							state <= aisk_pkg::AISK_ST_READY;
					end
				end
			endcase
		end
	end

	// ********************************************************************
	// command effects
	// ********************************************************************
	function automatic logic cmd_known(input logic [7:0] c, input logic [7:0] f);
		return c == `AISK_CMD_IDLE_A || c == `AISK_CMD_IDLE_B
			|| c == `AISK_CMD_IDLE_IMM_A || c == `AISK_CMD_IDLE_IMM_B
			|| c == `AISK_CMD_INIT_GEOM || c == `AISK_CMD_SEC_UNLOCK
			|| c == `AISK_CMD_SEC_ERASE
			|| (c == `AISK_CMD_KEY_MGMT && !f[`AISK_FEAT_KEY_HI]);
	endfunction : cmd_known

	always_comb begin
		int_events = '0;
		if (exec) begin
			int_events[`AISK_INT_ABORT] = !cmd_known(cmd_latched, feature_param)
				|| (sec_expired && (cmd_latched == `AISK_CMD_SEC_UNLOCK
				|| cmd_latched == `AISK_CMD_SEC_ERASE));
			int_events[`AISK_INT_DONE] = 1'b1;
			int_events[`AISK_INT_DRQ]  = cmd_latched == `AISK_CMD_KEY_MGMT
				&& !feature_param[`AISK_FEAT_KEY_HI];
		end
		int_events[`AISK_INT_PDOWN] = apd_expire;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heads_m1          <= `AISK_RST_HEADS_M1;
			sectors_per_track <= `AISK_RST_SPT;
		end else if (exec && cmd_latched == `AISK_CMD_INIT_GEOM) begin
			sectors_per_track <= transfer_count_param;
			heads_m1          <= unit_head_select[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			host_challenge_value <= 39'h0;
		else if (exec && cmd_latched == `AISK_CMD_KEY_MGMT)
			host_challenge_value <= {feature_param[6:0], transfer_count_param,
				start_sector_param, track_low_param, track_high_param};
	end

	// ********************************************************************
	// security and identify configuration
	// ********************************************************************
	// expiry is write-once from software; only reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_ctrl    <= 16'h0000;
			sec_expired <= 1'b0;
		end else if (wr_at(idx, wr, `AISK_IDX_SEC_CTRL)) begin
			sec_ctrl    <= pwdata[15:0];
			sec_expired <= sec_expired | pwdata[`AISK_SEC_EXPIRE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ident_ctrl <= 3'h0;
		else if (wr_at(idx, wr, `AISK_IDX_IDENT_CTRL))
			ident_ctrl <= pwdata[2:0];
	end

	// ********************************************************************
	// automatic power-down timer
	// ********************************************************************
	assign apd_tick   = tick_cnt == 18'(APD_TICK_CYCLES - 1);
	assign apd_expire = apd_enable && apd_tick && apd_left == 8'h01
		&& power != aisk_pkg::AISK_PWR_DOWN && !cmd_wr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apd_enable <= 1'b0;
			apd_count  <= 8'h00;
		end else if (exec && (cmd_latched == `AISK_CMD_IDLE_A
			|| cmd_latched == `AISK_CMD_IDLE_B)) begin
			apd_enable <= transfer_count_param != 8'h00;
			apd_count  <= transfer_count_param;
		end
	end

	// restart on every host command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 18'h0;
			apd_left <= 8'h00;
		end else if (cmd_wr || exec) begin
			tick_cnt <= 18'h0;
			apd_left <= exec && (cmd_latched == `AISK_CMD_IDLE_A
				|| cmd_latched == `AISK_CMD_IDLE_B) ? transfer_count_param : apd_count;
		end else if (apd_enable && power != aisk_pkg::AISK_PWR_DOWN
			&& state == aisk_pkg::AISK_ST_READY) begin
			tick_cnt <= apd_tick ? 18'h0 : tick_cnt + 18'h1;
			if (apd_tick && apd_left != 8'h00)
				apd_left <= apd_left - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power      <= aisk_pkg::AISK_PWR_ACTIVE;
			power_down <= 1'b0;
		end else if (cmd_wr) begin
			power      <= aisk_pkg::AISK_PWR_ACTIVE;
			power_down <= 1'b0;
		end else if (exec && (cmd_latched == `AISK_CMD_IDLE_A || cmd_latched == `AISK_CMD_IDLE_B
			|| cmd_latched == `AISK_CMD_IDLE_IMM_A || cmd_latched == `AISK_CMD_IDLE_IMM_B)) begin
			power <= aisk_pkg::AISK_PWR_IDLE;
		end else if (apd_expire) begin
			power      <= aisk_pkg::AISK_PWR_DOWN;
			power_down <= 1'b1;
		end
	end

	// ********************************************************************
	// interrupts: sticky, write one to clear, set wins
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= '0;
			int_mask   <= '0;
			irq        <= 1'b0;
		end else begin
			int_status <= (int_status & ~(wr_at(idx, wr, `AISK_IDX_INT_STAT) ?
				pwdata[`AISK_INT_W-1:0] : '0)) | int_events;
			if (wr_at(idx, wr, `AISK_IDX_INT_MASK))
				int_mask <= pwdata[`AISK_INT_W-1:0];
			irq <= |(int_status & int_mask);
		end
	end

endmodule : aisk_cmd

// file: testbench/aisk_cmd_properties.sv
// Purpose: port checks of the task-file command block
// Assumes: zero-wait apb slave, four-cycle busy
// Notes:   bound to every aisk_cmd
`timescale 1ns/1ps
module aisk_cmd_properties (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// status
	input wire logic        irq,
	input wire logic        device_occupied_flag,
	input wire logic        power_down
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire cmd_acc = psel && penable && pready && pwrite && paddr == 32'h1c;
	wire bad_adr = paddr[31:7] != '0 || paddr[1:0] != '0 || paddr[6:2] > 5'h11;
	property p_setup_ready; psel && !penable |=> pready; endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
	property p_ready_one; pready |-> $past(psel && !penable); endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready without setup");
	property p_err_map; pready |-> pslverr == bad_adr; endproperty
	a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
	property p_err_only; pslverr |-> pready; endproperty
	a_err_only: assert property (p_err_only) else $error("error flag outside access");
	property p_err_zero; pslverr && !pwrite |-> prdata == '0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
	property p_busy_len;
		$rose(device_occupied_flag) |-> device_occupied_flag[*4] ##1 !device_occupied_flag;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_busy_cause; $rose(device_occupied_flag) |-> $past(cmd_acc); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
	property p_wake; cmd_acc && power_down |=> !power_down; endproperty
	a_wake: assert property (p_wake) else $error("command did not wake");
endmodule : aisk_cmd_properties

bind aisk_cmd aisk_cmd_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .prdata, .pslverr, .irq, .device_occupied_flag, .power_down);

// file: testbench/aisk_host.sv
// Purpose: apb master standing in for the host controller
// Assumes: slave ends each access with pready
// Notes:   one idle cycle after each transfer
`timescale 1ns/1ps
module aisk_host (
	// clock
	input  wire logic        pclk,
	// apb request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      paddr,
	output logic [31:0]      pwdata,
	// apb answer
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: the bench timeout ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// stale values would hide a slave that samples outside its select
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask : xfer
endmodule : aisk_host

// file: testbench/tb.sv
// Purpose: self-checking bench of the task-file command block
// Assumes: short power-down tick of 10 cycles
// Notes:   expectations built from the register layout
`timescale 1ns/1ps
`include "aisk_defines.svh"
`define CHK(a, w) begin checks++; if ((a) !== (w)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, w); end end
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy, pd, e;
	logic [31:0] paddr, pwdata, prdata, q;
	int          mismatches, checks, cyc, i, n;
	logic [31:0] sw[4] = '{32'h12f, 32'h10d, 32'h001, 32'h010};
	logic [31:0] sr[4] = '{32'h12f, 32'h00d, 32'h001, 32'h010};
	logic [31:0] kw[4] = '{32'h5a01, 32'h2211, 32'h4433, 32'h5};
	aisk_cmd #(.APD_TICK_CYCLES(10)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .irq, .device_occupied_flag(busy), .power_down(pd));
	aisk_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr);
	task automatic wr(input logic [4:0] x, input logic [31:0] d);
		u_host.xfer(1'b1, {25'h0, x, 2'b00}, d, q, e);
	endtask : wr
	task automatic rd(input logic [4:0] x);
		u_host.xfer(1'b0, {25'h0, x, 2'b00}, 32'h0, q, e);
	endtask : rd
	// polls status up to 20 more times instead of counting, so a longer busy length still finishes
	task automatic cmd(input logic [7:0] c);
		wr(5'h07, {24'h0, c});
		rd(5'h08);
		`CHK(q[0], 1'b1)
		n = 0;
		while (q[0] !== 1'b0 && n < 20) begin
			rd(5'h08);
			n++;
		end
		`CHK(busy, 1'b0)
	endtask : cmd
	task automatic ints(input logic [3:0] w, input logic iw);
		rd(5'h09);
		`CHK(q, {28'h0, w})
		`CHK(irq, iw)
		wr(5'h09, 32'hf);
	endtask : ints
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(5'h0e);
		`CHK(q, 32'h00000f3f)
		u_host.xfer(1'b0, 32'h48, 32'h0, q, e);
		`CHK({e, q}, 33'h100000000)
		for (i = 0; i < 8; i++) begin
			wr(5'h0c, 32'(i));
			rd(5'h0d);
			`CHK(q[15:0], {14'h0, i != 0, 1'b1})
			`CHK(q[31:16], i[1] ? `AISK_PIO4_CYC_NS : i[0] ? `AISK_PIO3_CYC_NS : 16'h0)
		end
		cmd(`AISK_CMD_IDLE_IMM_A);
		rd(5'h09);
		`CHK(irq, 1'b0)
		wr(5'h0a, 32'hf);
		ints(4'h1, 1'b1);
		rd(5'h09);
		`CHK({irq, q}, 33'h0)
		for (i = 0; i < 4; i++) begin
			wr(5'h0b, sw[i]);
			rd(5'h0b);
			`CHK(q, sr[i])
		end
		cmd(`AISK_CMD_SEC_UNLOCK);
		ints(4'h5, 1'b1);
		cmd(`AISK_CMD_SEC_ERASE);
		rd(5'h08);
		`CHK(q[2], 1'b1)
		ints(4'h5, 1'b1);
		wr(5'h02, 32'h3);
		cmd(`AISK_CMD_IDLE_A);
		rd(5'h11);
		`CHK({q[16], q[7:0]}, 9'h103)
		n = 0;
		do begin
			rd(5'h08);
			n++;
		end while (q[4:3] !== 2'h2 && n < 40);
		`CHK(n > 5 && n < 14, 1'b1)
		`CHK(pd, 1'b1)
		ints(4'h9, 1'b1);
		cmd(`AISK_CMD_IDLE_IMM_B);
		`CHK(pd, 1'b0)
		ints(4'h1, 1'b1);
		wr(5'h02, 32'h0);
		cmd(`AISK_CMD_IDLE_B);
		for (i = 0; i < 16; i++) rd(5'h08);
		`CHK({pd, q[4:3]}, 3'h1)
		rd(5'h11);
		`CHK(q[16], 1'b0)
		ints(4'h1, 1'b1);
		for (i = 1; i < 7; i++) wr(5'(i), 32'hff);
		wr(5'h02, 32'h21);
		wr(5'h06, 32'ha5);
		cmd(`AISK_CMD_INIT_GEOM);
		rd(5'h0e);
		`CHK(q, 32'h00000521)
		ints(4'h1, 1'b1);
		wr(5'h01, 32'h05);
		for (i = 2; i < 6; i++) wr(5'(i), 32'(17 * (6 - i)));
		cmd(`AISK_CMD_KEY_MGMT);
		rd(5'h08);
		`CHK(q[1], 1'b1)
		rd(5'h0f);
		`CHK(q, 32'h44332211)
		rd(5'h10);
		`CHK(q, 32'h5)
		for (i = 0; i < 256; i++) begin
			rd(5'h00);
			`CHK(q, i < 4 ? kw[i] : 32'h0)
		end
		rd(5'h08);
		`CHK(q[2:0], 3'h0)
		wr(5'h09, 32'hf);
		wr(5'h01, 32'h80);
		cmd(`AISK_CMD_KEY_MGMT);
		ints(4'h5, 1'b1);
		complete_run();
	end
endmodule : tb
